// file: nps_power_ctrl.sv
`timescale 1ns/10ps
// Operation
// - Enter uninitialized-on from reset-hold or D3hot
// - Power-good: clear, load NVM, then link
// - D3 exit keeps configuration space unchanged
// - Space-enable write moves uninitialized to active
// - Active APM wake persists until software clears
// - Power-state 11b enters D3hot, keeps filters
// - D3 clears enables, config only, no mastering
// - Fundamental reset in D3hot enters reset-hold
// - D3 drains TLPs then link to L1
// - Hold receive data in D3, discard on exit
// - D3 entry with wake lowers PHY speed
// - Reset-hold from power-on until power-good
// - Fundamental reset high level leaves reset-hold
// - Wake filters preserved through reset-hold
// - Boot NVM sets APM; link off in reset
// - Active to reset-hold with wake lowers speed
// - Link L2 from D3hot with PME, else L3
// - Device-off: L3, PHY down, clocks gated
// - Device-off ignores reset, brief NVM exit
// - Ethernet disconnect enters link-disconnect state
// - NVM load before uninitialized disables wake, resets PHY
module nps_power_ctrl
  import nps_pkg::*;
#(
  parameter int WAKE_FILTER_CONTROL_REG_WIDTH = 32
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [NPS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and power status.
  input wire logic pcie_fundamental_reset_pin_n,
  input wire logic device_off_input_n,
  input wire logic internal_power_good,
  // PCIe core.
  input wire logic pcie_link_up,
  input wire logic tlp_pending,
  output logic [1:0] pcie_link_state,
  output logic pcie_link_enable,
  output logic tlp_sched_stop,
  // NVM loader.
  output logic nvm_load_req,
  input wire logic nvm_load_done,
  input wire nps_nvm_t nvm_cfg,
  // PHY, MAC and DMA.
  input wire logic eth_link_disconnect,
  output nps_phy_ctrl_t phy_ctrl,
  output logic dma_enable,
  output logic mac_enable,
  output logic mng_enable,
  output logic apm_wake_enable,
  output logic [WAKE_FILTER_CONTROL_REG_WIDTH-1:0] wake_filter_enable,
  output logic rx_hold,
  output logic rx_discard,
  output logic clocks_gated,
  output logic outputs_tristate,
  output logic link_disconnect_mode
);

  if (WAKE_FILTER_CONTROL_REG_WIDTH < 1 || WAKE_FILTER_CONTROL_REG_WIDTH > 32) begin : g_bad_width
    $error("WAKE_FILTER_CONTROL_REG_WIDTH must lie between 1 and 32");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // A level is accepted only once the second and third stages agree.
  logic [2:0] async_in;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] filt_reg;
  logic pin_prev_reg;
  logic pg_prev_reg;

  assign async_in = {eth_link_disconnect, device_off_input_n, pcie_fundamental_reset_pin_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= NPS_SYNC_RST;
      s2_reg <= NPS_SYNC_RST;
      s3_reg <= NPS_SYNC_RST;
      filt_reg <= NPS_SYNC_RST;
      pin_prev_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      pin_prev_reg <= filt_reg[0];
      pg_prev_reg <= internal_power_good;
    end
  end

  wire pin_rise = filt_reg[0] & ~pin_prev_reg;
  wire pin_fall = ~filt_reg[0] & pin_prev_reg;
  wire pg_rise = internal_power_good & ~pg_prev_reg;
  wire dev_off = ~filt_reg[1];
  wire eth_disc = filt_reg[2];

  // ****************************************************************
  // Register state and APB decode
  // ****************************************************************
  nps_state_t state_reg;
  nps_state_t state_next;
  logic [1:0] ps_reg;
  logic pme_en_reg;
  logic io_en_reg;
  logic mem_en_reg;
  logic apm_wake_enable_bit_reg;
  logic mng_cfg_reg;
  logic aux_pm_en_reg;
  logic [WAKE_FILTER_CONTROL_REG_WIDTH-1:0] wake_filter_control_reg_reg;
  logic [1:0] l23_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic [3:0] mode;

  wire hit_pm = paddr == NPS_OFF_PMCSR;
  wire hit_cmd = paddr == NPS_OFF_COMMAND;
  wire hit_wuc = paddr == NPS_OFF_WAKE_CTRL;
  wire hit_wake_filter_control_reg = paddr == NPS_OFF_WAKE_FILTER;
  wire hit_stat = paddr == NPS_OFF_STATUS;
  wire hit_aux = paddr == NPS_OFF_AUX_CTRL;
  wire hit_csr = hit_wuc | hit_wake_filter_control_reg;
  wire mapped = hit_pm | hit_cmd | hit_csr | hit_stat | hit_aux;
  // Configuration is answered only once the link is up; device CSRs need memory decode.
  wire cfg_open = state_reg inside {ST_UNINIT, ST_ACTIVE, ST_D3_DRAIN, ST_D3HOT};
  wire csr_open = mem_en_reg & (state_reg inside {ST_UNINIT, ST_ACTIVE});
  wire acc_err = ~mapped | ~cfg_open | (hit_csr & ~csr_open);
  wire apb_fire = psel & penable & pready_reg;
  wire wr_ok = apb_fire & pwrite & ~pslverr_reg;
  wire wr_pm = wr_ok & hit_pm;
  wire wr_cmd = wr_ok & hit_cmd;
  wire pm_to_d3 = wr_pm & (pwdata[NPS_PMCSR_PS_LSB +: 2] == NPS_PS_D3);
  wire pm_to_d0 = wr_pm & (pwdata[NPS_PMCSR_PS_LSB +: 2] == NPS_PS_D0);
  wire space_on = wr_cmd & (pwdata[NPS_CMD_IO_EN] | pwdata[NPS_CMD_MEM_EN]);
  wire wake_any = mng_cfg_reg | apm_wake_enable_bit_reg | pme_en_reg | aux_pm_en_reg;

  // ****************************************************************
  // Power-state sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT_LOAD: if (nvm_load_done) state_next = ST_RESET_HOLD;
      ST_RESET_HOLD: if (filt_reg[0] || pg_rise) state_next = ST_NVM_LOAD;
      ST_NVM_LOAD: if (nvm_load_done) state_next = ST_LINK_TRAIN;
      ST_LINK_TRAIN: if (pcie_link_up) state_next = ST_UNINIT;
      ST_UNINIT: begin
        if (pm_to_d3) state_next = ST_D3_DRAIN;
        else if (space_on) state_next = ST_ACTIVE;
      end
      ST_ACTIVE: if (pm_to_d3) state_next = ST_D3_DRAIN;
      ST_D3_DRAIN: if (!tlp_pending) state_next = ST_D3HOT;
      ST_D3HOT: if (pm_to_d0) state_next = ST_NVM_LOAD;
      ST_DISABLE: begin
        if (!dev_off) state_next = ST_RESET_HOLD;
        else if (pin_rise) state_next = ST_OFF_LOAD;
      end
      ST_OFF_LOAD: if (nvm_load_done) state_next = dev_off ? ST_DISABLE : ST_RESET_HOLD;
    endcase
    if (pin_fall && !(state_reg inside {ST_BOOT_LOAD, ST_DISABLE, ST_OFF_LOAD})) begin
      state_next = ST_RESET_HOLD;
    end
    if (dev_off && !(state_reg inside {ST_DISABLE, ST_OFF_LOAD})) begin
      state_next = ST_DISABLE;
    end
  end

  wire enter_init = state_reg == ST_RESET_HOLD && state_next == ST_NVM_LOAD;
  wire enter_load = state_reg != ST_NVM_LOAD && state_next == ST_NVM_LOAD;
  wire enter_d3 = state_reg != ST_D3_DRAIN && state_next == ST_D3_DRAIN;
  wire enter_hold = state_reg != ST_RESET_HOLD && state_next == ST_RESET_HOLD;
  wire nvm_done = nvm_load_done & (state_reg inside {ST_BOOT_LOAD, ST_NVM_LOAD, ST_OFF_LOAD});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_reg <= ST_BOOT_LOAD;
    else state_reg <= state_next;
  end

  // ****************************************************************
  // Configuration and wake registers
  // ****************************************************************
  // The reset-hold exit, on power-good or reset release, clears configuration; D3 entry clears only the decode enables; D3 exit leaves it for software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_reg <= NPS_PS_D0;
      io_en_reg <= 1'b0;
      mem_en_reg <= 1'b0;
      aux_pm_en_reg <= 1'b0;
    end else if (enter_init) begin
      ps_reg <= NPS_PS_D0;
      io_en_reg <= 1'b0;
      mem_en_reg <= 1'b0;
      aux_pm_en_reg <= 1'b0;
    end else if (enter_d3) begin
      ps_reg <= NPS_PS_D3;
      io_en_reg <= 1'b0;
      mem_en_reg <= 1'b0;
    end else begin
      if (wr_pm) ps_reg <= pwdata[NPS_PMCSR_PS_LSB +: 2];
      if (wr_cmd) io_en_reg <= pwdata[NPS_CMD_IO_EN];
      if (wr_cmd) mem_en_reg <= pwdata[NPS_CMD_MEM_EN];
      if (wr_ok && hit_aux) aux_pm_en_reg <= pwdata[NPS_AUX_PM_EN];
    end
  end

  // Sticky wake state survives everything but the power-on reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_en_reg <= 1'b0;
      wake_filter_control_reg_reg <= '0;
    end else begin
      if (wr_pm) pme_en_reg <= pwdata[NPS_PMCSR_PME_EN];
      if (wr_ok && hit_wake_filter_control_reg) wake_filter_control_reg_reg <= pwdata[WAKE_FILTER_CONTROL_REG_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apm_wake_enable_bit_reg <= 1'b0;
      mng_cfg_reg <= 1'b0;
    end else if (enter_load) begin
      apm_wake_enable_bit_reg <= 1'b0;
    end else if (nvm_done) begin
      apm_wake_enable_bit_reg <= nvm_cfg.apm_en;
      mng_cfg_reg <= nvm_cfg.mng_en;
    end else if (wr_ok && hit_wuc) begin
      apm_wake_enable_bit_reg <= pwdata[NPS_WUC_APM_WAKE_ENABLE_BIT];
    end
  end

  // The link level to show in reset-hold depends on where it was entered from.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) l23_reg <= NPS_LINK_L3;
    else if (enter_hold) l23_reg <= (state_reg == ST_D3HOT && pme_en_reg) ? NPS_LINK_L2 : NPS_LINK_L3;
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  always_comb begin
    unique case (state_reg)
      ST_BOOT_LOAD, ST_RESET_HOLD: mode = NPS_MODE_RESET_HOLD;
      ST_UNINIT: mode = NPS_MODE_UNINIT;
      ST_ACTIVE: mode = NPS_MODE_ACTIVE;
      ST_D3_DRAIN, ST_D3HOT: mode = NPS_MODE_D3HOT;
      ST_DISABLE, ST_OFF_LOAD: mode = NPS_MODE_DISABLE;
      default: mode = NPS_MODE_BUSY;
    endcase
    rd_data = '0;
    if (hit_pm) begin
      rd_data[NPS_PMCSR_PS_LSB +: 2] = ps_reg;
      rd_data[NPS_PMCSR_PME_EN] = pme_en_reg;
    end
    if (hit_cmd) begin
      rd_data[NPS_CMD_IO_EN] = io_en_reg;
      rd_data[NPS_CMD_MEM_EN] = mem_en_reg;
    end
    if (hit_wuc) rd_data[NPS_WUC_APM_WAKE_ENABLE_BIT] = apm_wake_enable_bit_reg;
    if (hit_wake_filter_control_reg) rd_data[WAKE_FILTER_CONTROL_REG_WIDTH-1:0] = wake_filter_control_reg_reg;
    if (hit_aux) rd_data[NPS_AUX_PM_EN] = aux_pm_en_reg;
    if (hit_stat) begin
      rd_data[NPS_STAT_MODE_LSB +: 4] = mode;
      rd_data[NPS_STAT_ENERGY] = ~eth_disc;
      rd_data[NPS_STAT_DISC] = link_disconnect_mode;
      rd_data[NPS_STAT_LINK_LSB +: 2] = pcie_link_state;
    end
  end

  // Registered answer costs one wait state but keeps every bus output on a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & acc_err;
      prdata_reg <= (psel & penable & ~pready_reg & ~acc_err & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ****************************************************************
  // Outputs to PHY, MAC, DMA and link
  // ****************************************************************
  logic [1:0] link_reg;
  logic link_en_reg;
  logic sched_stop_reg;
  logic nvm_req_reg;
  nps_phy_ctrl_t phy_reg;
  logic dma_reg;
  logic mng_reg;
  logic rx_hold_reg;
  logic rx_discard_reg;
  logic gated_reg;
  logic disc_reg;

  wire next_off = state_next inside {ST_DISABLE, ST_OFF_LOAD};
  wire next_d3 = state_next inside {ST_D3_DRAIN, ST_D3HOT};
  wire lower_speed = (enter_d3 || (state_reg == ST_ACTIVE && enter_hold) ||
                      (state_reg == ST_BOOT_LOAD && nvm_done)) && wake_any;
  wire [1:0] l23_reg_next = (state_reg == ST_D3HOT && pme_en_reg) ? NPS_LINK_L2 : NPS_LINK_L3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reg <= NPS_LINK_L3;
      link_en_reg <= 1'b0;
      sched_stop_reg <= 1'b1;
      nvm_req_reg <= 1'b1;
      dma_reg <= 1'b0;
      mng_reg <= 1'b0;
    end else begin
      link_reg <= next_off ? NPS_LINK_L3 :
                  state_next == ST_D3HOT ? NPS_LINK_L1 :
                  state_next inside {ST_BOOT_LOAD, ST_RESET_HOLD} ? (enter_hold ? l23_reg_next : l23_reg) :
                  NPS_LINK_L0;
      link_en_reg <= !(state_next inside {ST_BOOT_LOAD, ST_RESET_HOLD}) && !next_off;
      sched_stop_reg <= state_next != ST_ACTIVE;
      nvm_req_reg <= state_next inside {ST_BOOT_LOAD, ST_NVM_LOAD, ST_OFF_LOAD};
      dma_reg <= state_next == ST_ACTIVE;
      mng_reg <= state_next == ST_ACTIVE && mng_cfg_reg;
    end
  end


  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_reg <= '{reset: 1'b1, low_speed: 1'b0, power_down: 1'b0};
      rx_hold_reg <= 1'b0;
      rx_discard_reg <= 1'b0;
      gated_reg <= 1'b0;
      disc_reg <= 1'b0;
    end else begin
      phy_reg.reset <= state_next inside {ST_BOOT_LOAD, ST_NVM_LOAD, ST_OFF_LOAD};
      phy_reg.power_down <= state_next == ST_DISABLE;
      if (state_next == ST_ACTIVE) phy_reg.low_speed <= 1'b0;
      else if (lower_speed) phy_reg.low_speed <= 1'b1;
      rx_hold_reg <= next_d3;
      rx_discard_reg <= state_reg == ST_D3HOT && !next_d3;
      gated_reg <= state_next == ST_DISABLE;
      disc_reg <= eth_disc && (state_next inside {ST_UNINIT, ST_ACTIVE, ST_D3_DRAIN, ST_D3HOT, ST_RESET_HOLD});
    end
  end

  assign pcie_link_state = link_reg;
  assign pcie_link_enable = link_en_reg;
  assign tlp_sched_stop = sched_stop_reg;
  assign nvm_load_req = nvm_req_reg;
  assign phy_ctrl = phy_reg;
  assign dma_enable = dma_reg;
  assign mac_enable = dma_reg;
  assign mng_enable = mng_reg;
  assign apm_wake_enable = apm_wake_enable_bit_reg;
  assign wake_filter_enable = wake_filter_control_reg_reg;
  assign rx_hold = rx_hold_reg;
  assign rx_discard = rx_discard_reg;
  assign clocks_gated = gated_reg;
  assign outputs_tristate = gated_reg;
  assign link_disconnect_mode = disc_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_D3_NO_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_D3HOT |-> !mem_en_reg && !io_en_reg && !dma_enable) else $error("D3 with decode or DMA on");
  AST_SPACE_ON: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_UNINIT && space_on && !pm_to_d3 && !dev_off && !pin_fall |=> state_reg == ST_ACTIVE && dma_enable)
    else $error("Space enable did not activate");
  AST_D3_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_ACTIVE && pm_to_d3 && !dev_off && !pin_fall |=> state_reg == ST_D3_DRAIN && $stable(wake_filter_control_reg_reg))
    else $error("D3 request not taken");
  AST_DRAIN_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_D3_DRAIN && tlp_pending && !dev_off && !pin_fall |=> state_reg == ST_D3_DRAIN && tlp_sched_stop)
    else $error("Left drain with TLPs pending");
  AST_D3_TO_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_D3HOT && pin_fall && !dev_off |=> state_reg == ST_RESET_HOLD &&
    pcie_link_state == ($past(pme_en_reg) ? NPS_LINK_L2 : NPS_LINK_L3) && rx_discard)
    else $error("Reset from D3 mishandled");
  AST_HOLD_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_RESET_HOLD && pin_rise && !dev_off |=> state_reg == ST_NVM_LOAD && nvm_load_req && !mem_en_reg)
    else $error("Reset release did not start load");
  AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    dev_off && !(state_reg inside {ST_OFF_LOAD}) |=> state_reg inside {ST_DISABLE, ST_OFF_LOAD} &&
    (state_reg != ST_DISABLE || (clocks_gated && pcie_link_state == NPS_LINK_L3)))
    else $error("Device-off not honoured");
  AST_LOAD_PHY: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_NVM_LOAD |-> phy_ctrl.reset && !apm_wake_enable) else $error("Load without PHY reset");
  AST_HOLD_FILTERS: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_RESET_HOLD |=> $stable(wake_filter_control_reg_reg)) else $error("Filters changed in reset-hold");
  AST_DISCONNECT: assert property (@(posedge pclk) disable iff (!presetn)
    eth_disc && state_reg == ST_ACTIVE && state_next == ST_ACTIVE |=> link_disconnect_mode)
    else $error("Disconnect not entered");

endmodule : nps_power_ctrl

// file: nps_pkg.sv
package nps_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int NPS_ADDR_W = 8;
  localparam logic [7:0] NPS_OFF_PMCSR = 8'h00;
  localparam logic [7:0] NPS_OFF_COMMAND = 8'h04;
  localparam logic [7:0] NPS_OFF_WAKE_CTRL = 8'h08;
  localparam logic [7:0] NPS_OFF_WAKE_FILTER = 8'h0C;
  localparam logic [7:0] NPS_OFF_STATUS = 8'h10;
  localparam logic [7:0] NPS_OFF_AUX_CTRL = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int NPS_PMCSR_PS_LSB = 0;
  localparam int NPS_PMCSR_PME_EN = 8;
  localparam int NPS_CMD_IO_EN = 0;
  localparam int NPS_CMD_MEM_EN = 1;
  localparam int NPS_WUC_APM_WAKE_ENABLE_BIT = 0;
  localparam int NPS_AUX_PM_EN = 0;
  localparam int NPS_STAT_MODE_LSB = 0;
  localparam int NPS_STAT_ENERGY = 4;
  localparam int NPS_STAT_DISC = 5;
  localparam int NPS_STAT_LINK_LSB = 6;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] NPS_PS_D0 = 2'h0;
  localparam logic [1:0] NPS_PS_D3 = 2'h3;
  localparam logic [1:0] NPS_LINK_L0 = 2'h0;
  localparam logic [1:0] NPS_LINK_L1 = 2'h1;
  localparam logic [1:0] NPS_LINK_L2 = 2'h2;
  localparam logic [1:0] NPS_LINK_L3 = 2'h3;
  localparam logic [3:0] NPS_MODE_RESET_HOLD = 4'h0;
  localparam logic [3:0] NPS_MODE_UNINIT = 4'h1;
  localparam logic [3:0] NPS_MODE_ACTIVE = 4'h2;
  localparam logic [3:0] NPS_MODE_D3HOT = 4'h3;
  localparam logic [3:0] NPS_MODE_DISABLE = 4'h4;
  localparam logic [3:0] NPS_MODE_BUSY = 4'h5;
  // Synchroniser reset levels: bit0 fundamental reset (asserted), bit1 device off (released), bit2 disconnect.
  localparam logic [2:0] NPS_SYNC_RST = 3'h2;

  typedef enum logic [3:0] {
    ST_BOOT_LOAD, ST_RESET_HOLD, ST_NVM_LOAD, ST_LINK_TRAIN, ST_UNINIT,
    ST_ACTIVE, ST_D3_DRAIN, ST_D3HOT, ST_DISABLE, ST_OFF_LOAD
  } nps_state_t;

  typedef struct packed {
    logic reset;
    logic low_speed;
    logic power_down;
  } nps_phy_ctrl_t;

  typedef struct packed {
    logic apm_en;
    logic mng_en;
  } nps_nvm_t;

endpackage : nps_pkg

// file: nps_host_model.sv
`timescale 1ns/10ps
// ****
// Loader and PCIe core stand-in
// ****
// The drain counter reloads whenever scheduling runs, so every D3 entry from active sees a slow drain.
module nps_host_model
  import nps_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the block.
  input wire logic nvm_load_req,
  input wire logic pcie_link_enable,
  input wire logic tlp_sched_stop,
  // Answers to the block.
  output logic nvm_load_done,
  output logic pcie_link_up,
  output logic tlp_pending
);
  logic [3:0] load_cnt_reg;
  logic [2:0] drain_cnt_reg;
  assign tlp_pending = tlp_sched_stop && (drain_cnt_reg != 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_reg <= 4'h0;
      nvm_load_done <= 1'b0;
      pcie_link_up <= 1'b0;
      drain_cnt_reg <= 3'h0;
    end else begin
      load_cnt_reg <= (nvm_load_req && !nvm_load_done) ? load_cnt_reg + 4'h1 : 4'h0;
      nvm_load_done <= (load_cnt_reg == 4'h5);
      pcie_link_up <= pcie_link_enable;
      drain_cnt_reg <= !tlp_sched_stop ? 3'h4 : (drain_cnt_reg != 3'h0 ? drain_cnt_reg - 3'h1 : 3'h0);
    end
  end
endmodule : nps_host_model

// file: nps_power_ctrl_tb.sv
`timescale 1ns/10ps
module nps_power_ctrl_tb;
  import nps_pkg::*;
  // ****
  // Bench signals
  // ****
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, wfe;
  logic pready, pslverr, err, pin_n = 0, off_n = 1, pgood = 0, disc = 0;
  logic up, tlp, req, done, lk_en, stop, dma, mac, mng, apm, hold, disc_m, gated, tri_o;
  logic rx_disc, dsc_seen = 0;
  logic [1:0] lk;
  nps_phy_ctrl_t phy;
  nps_nvm_t cfg = '{apm_en: 1'b1, mng_en: 1'b0};
  int errors = 0, comparisons = 0;
  always #12.5 pclk = ~pclk;
  // The discard strobe lasts one cycle, so it is latched here for the exit test.
  always @(posedge pclk) if (rx_disc === 1'b1) dsc_seen <= 1'b1;
  nps_power_ctrl nps_power_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pcie_fundamental_reset_pin_n(pin_n), .device_off_input_n(off_n), .internal_power_good(pgood),
    .pcie_link_up(up), .tlp_pending(tlp), .pcie_link_state(lk), .pcie_link_enable(lk_en),
    .tlp_sched_stop(stop), .nvm_load_req(req), .nvm_load_done(done), .nvm_cfg(cfg),
    .eth_link_disconnect(disc), .phy_ctrl(phy), .dma_enable(dma), .mac_enable(mac), .mng_enable(mng),
    .apm_wake_enable(apm), .wake_filter_enable(wfe), .rx_hold(hold), .rx_discard(rx_disc),
    .clocks_gated(gated), .outputs_tristate(tri_o), .link_disconnect_mode(disc_m));
  nps_host_model nps_host_model_inst (.pclk(pclk), .presetn(presetn), .nvm_load_req(req),
    .pcie_link_enable(lk_en), .tlp_sched_stop(stop), .nvm_load_done(done), .pcie_link_up(up),
    .tlp_pending(tlp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Polls status; reads are refused until configuration opens.
  task automatic wait_mode(input logic [3:0] m);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(0, NPS_OFF_STATUS, 32'h0);
      if (err === 1'b0 && rd[3:0] === m) break;
    end
    if (n == 300) begin
      errors++;
      conclude();
    end
  endtask : wait_mode
  task automatic t_boot;
    apb(0, NPS_OFF_STATUS, 32'h0);
    check(err, 1);
    check(phy.reset, 1);
    check(lk_en, 0);
    pin_n <= 1;
    pgood <= 1;
    wait_mode(NPS_MODE_UNINIT);
    check(lk_en, 1);
    check(apm, cfg.apm_en);
    apb(1, NPS_OFF_WAKE_CTRL, 32'h0);
    check(err, 1);
    apb(0, 8'h20, 32'h0);
    check(err, 1);
    $display("test boot done");
  endtask : t_boot
  task automatic t_active;
    apb(1, NPS_OFF_COMMAND, 32'h2);
    wait_mode(NPS_MODE_ACTIVE);
    check({dma, mac, mng, apm}, {2'b11, cfg.mng_en, 1'b1});
    check(stop, 0);
    apb(1, NPS_OFF_WAKE_FILTER, 32'hA5A50F0F);
    apb(1, NPS_OFF_AUX_CTRL, 32'h1);
    $display("test active done");
  endtask : t_active
  // Interrupts, tails and mastering stay quiet before D3; PME is armed with it.
  task automatic t_d3;
    apb(1, NPS_OFF_PMCSR, 32'h100);
    apb(1, NPS_OFF_PMCSR, 32'h103);
    wait_mode(NPS_MODE_D3HOT);
    // Status shows D3 during the drain as well, so the drain is let finish before the link is judged.
    repeat (8) @(posedge pclk);
    check({lk, hold, phy.low_speed, dma, stop}, {NPS_LINK_L1, 4'hD});
    check(wfe, 32'hA5A50F0F);
    apb(0, NPS_OFF_COMMAND, 32'h0);
    check(rd[1:0], 2'h0);
    apb(1, NPS_OFF_WAKE_CTRL, 32'h0);
    check(err, 1);
    $display("test d3 done");
  endtask : t_d3
  task automatic t_exit;
    apb(1, NPS_OFF_PMCSR, 32'h100);
    wait_mode(NPS_MODE_UNINIT);
    apb(0, NPS_OFF_AUX_CTRL, 32'h0);
    check(rd, 32'h1);
    check(wfe, 32'hA5A50F0F);
    check(hold, 0);
    check(dsc_seen, 1);
    $display("test exit done");
  endtask : t_exit
  // Link goes to L2 with PME armed before the reset pin falls.
  task automatic t_reset_off;
    pin_n <= 0;
    pgood <= 0;
    repeat (10) @(posedge pclk);
    apb(0, NPS_OFF_STATUS, 32'h0);
    check(err, 1);
    check(lk, NPS_LINK_L2);
    check(lk_en, 0);
    check(wfe, 32'hA5A50F0F);
    off_n <= 0;
    repeat (10) @(posedge pclk);
    check({gated, tri_o, phy.power_down, lk}, {3'h7, NPS_LINK_L3});
    // A reset release while disabled runs one NVM load and then falls back to device-off.
    pin_n <= 1;
    pgood <= 1;
    repeat (24) @(posedge pclk);
    check({gated, lk}, {1'b1, NPS_LINK_L3});
    off_n <= 1;
    wait_mode(NPS_MODE_UNINIT);
    apb(0, NPS_OFF_AUX_CTRL, 32'h0);
    check(rd, 32'h0);
    disc <= 1;
    repeat (10) @(posedge pclk);
    apb(0, NPS_OFF_STATUS, 32'h0);
    check({disc_m, rd[5:4]}, 3'h6);
    $display("test reset and off done");
  endtask : t_reset_off
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_boot();
    t_active();
    t_d3();
    t_exit();
    t_active();
    t_d3();
    t_reset_off();
    conclude();
  end
endmodule : nps_power_ctrl_tb
